// *** rtl/down_timer_pkg.sv ***
// register map, field positions and reset values of the down timer
package down_timer_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_TIMER_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_TIMER_CTRL_B = 8'h04;
   localparam logic [7:0] OFS_RELOAD_LOW = 8'h08;
   localparam logic [7:0] OFS_SHARED_HIGH = 8'h0c;
   localparam logic [7:0] OFS_CH_A_DUTY = 8'h10;
   localparam logic [7:0] OFS_CH_B_CTRL = 8'h14;
   localparam logic [7:0] OFS_CH_B_DUTY = 8'h18;
   localparam logic [7:0] OFS_CH_C_CTRL = 8'h1c;
   localparam logic [7:0] OFS_CH_C_DUTY = 8'h20;
   localparam logic [7:0] OFS_CH_C_HIGH = 8'h24;
   localparam logic [7:0] OFS_IRQ_REG_TWO = 8'h28;
   localparam logic [7:0] OFS_PRESCALE_READ = 8'h2c;
   localparam logic [7:0] OFS_GLOBAL_IRQ = 8'h30;
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int BIT_RUN = 0;
   localparam int BIT_RELOAD = 1;
   localparam int BIT_ONESHOT = 2;
   localparam int BIT_POL = 6;
   localparam int BIT_OEN = 7;
   localparam int BIT_SRC = 5;
   localparam int BIT_EDGE = 4;
   localparam int BIT_PS_EN_N = 3;
   localparam int BIT_UF_FLAG = 4;
   localparam int BIT_UF_IE = 0;
   localparam int BIT_RELOAD_HI = 4;
   localparam int BIT_B_HI = 2;
   localparam int BIT_A_HI = 0;
   // ************************************************************
   // reset and special values
   // ************************************************************
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_CTRL_B = 8'h08;
   localparam logic [9:0] RST_COUNT = 10'h3ff;
   localparam logic [9:0] FREE_RUN_START = 10'h3ff;
endpackage : down_timer_pkg

// *** rtl/down_timer_triple_pwm.sv ***
// 10-bit down timer with prescaler and three shared-frame pwm channels
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 10-bit down counter behind programmable prescaler
// - reload buffered, applied at underflow while running
// - stopped: low byte write loads counter
// - reading timer returns live count
// - run bit starts and stops counting
// - source select: pin or instruction clock
// - edge select: falling when one
// - prescaler enable low, ratio 1:2..1:256
// - prescaler count readable
// - one-shot counts down once then stops
// - free-run restarts from reload or 0x3ff
// - underflow flag sticky, gated interrupt request
// - channel a enable drives chosen pin
// - channel a polarity select
// - duty zero never active, high bits shared
// - channel a duty applied at underflow
// - channel b mirrors a, high bits 3:2
// - channel c mirrors a, own high register
// - channels b, c duty applied at underflow
module down_timer_triple_pwm
   import down_timer_pkg::*;
#(
   parameter int CNT_W = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_count_pin,
   input wire logic [2:0] pin_sel,
   output logic irq_req,
   output logic [2:0] pwm_level,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe
);
   import down_timer_pkg::*;

   // ************************************************************
   // bus slave
   // ************************************************************
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rdata_r;
   logic [7:0] ctrl_a_r, ctrl_b_r, ch_b_ctrl_r, ch_c_ctrl_r;
   logic [7:0] reload_low_r, shared_high_r, ch_c_high_r;
   logic [7:0] duty_a_low_r, duty_b_low_r, duty_c_low_r;
   logic [9:0] duty_a_r, duty_b_r, duty_c_r;
   logic [CNT_W-1:0] count_r;
   logic [7:0] ps_count_r;
   logic uf_flag_r, uf_ie_r, gie_r;
   logic underflow;
   logic wr_now;
   logic rd_take;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign wr_now = wr_pend_r;

   function automatic logic is_wr(input logic [7:0] ofs, input logic [7:0] a,
                                  input logic p);
      is_wr = p && (a == ofs);
   endfunction : is_wr

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= hsel && hready && htrans[1] && hwrite;
         wr_addr_r <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_a_r <= RST_CTRL;
         ctrl_b_r <= RST_CTRL_B;
         ch_b_ctrl_r <= RST_CTRL;
         ch_c_ctrl_r <= RST_CTRL;
         reload_low_r <= RST_COUNT[7:0];
         shared_high_r <= {2'b00, RST_COUNT[9:8], 4'h0};
         ch_c_high_r <= 8'h00;
         duty_a_low_r <= 8'h00;
         duty_b_low_r <= 8'h00;
         duty_c_low_r <= 8'h00;
         uf_ie_r <= 1'b0;
         gie_r <= 1'b0;
      end else if (wr_now) begin
         if (is_wr(OFS_TIMER_CTRL_A, wr_addr_r, 1'b1)) ctrl_a_r <= hwdata[7:0];
         if (is_wr(OFS_TIMER_CTRL_B, wr_addr_r, 1'b1)) ctrl_b_r <= hwdata[7:0];
         if (is_wr(OFS_CH_B_CTRL, wr_addr_r, 1'b1)) ch_b_ctrl_r <= hwdata[7:0];
         if (is_wr(OFS_CH_C_CTRL, wr_addr_r, 1'b1)) ch_c_ctrl_r <= hwdata[7:0];
         if (is_wr(OFS_RELOAD_LOW, wr_addr_r, 1'b1)) reload_low_r <= hwdata[7:0];
         if (is_wr(OFS_SHARED_HIGH, wr_addr_r, 1'b1)) shared_high_r <= {2'b00, hwdata[5:0]};
         if (is_wr(OFS_CH_C_HIGH, wr_addr_r, 1'b1)) ch_c_high_r <= {6'h00, hwdata[1:0]};
         if (is_wr(OFS_CH_A_DUTY, wr_addr_r, 1'b1)) duty_a_low_r <= hwdata[7:0];
         if (is_wr(OFS_CH_B_DUTY, wr_addr_r, 1'b1)) duty_b_low_r <= hwdata[7:0];
         if (is_wr(OFS_CH_C_DUTY, wr_addr_r, 1'b1)) duty_c_low_r <= hwdata[7:0];
         if (is_wr(OFS_IRQ_REG_TWO, wr_addr_r, 1'b1)) uf_ie_r <= hwdata[BIT_UF_IE];
         if (is_wr(OFS_GLOBAL_IRQ, wr_addr_r, 1'b1)) gie_r <= hwdata[0];
      end
   end

   // read data registered at address phase; bus answers with zero waits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd_take) begin
         case (haddr)
            OFS_TIMER_CTRL_A: rdata_r <= {24'h0, ctrl_a_r};
            OFS_TIMER_CTRL_B: rdata_r <= {24'h0, ctrl_b_r};
            OFS_RELOAD_LOW: rdata_r <= {24'h0, count_r[7:0]};
            OFS_SHARED_HIGH: rdata_r <= {26'h0, count_r[9:8], shared_high_r[3:0]};
            OFS_CH_A_DUTY: rdata_r <= {24'h0, duty_a_low_r};
            OFS_CH_B_CTRL: rdata_r <= {24'h0, ch_b_ctrl_r};
            OFS_CH_B_DUTY: rdata_r <= {24'h0, duty_b_low_r};
            OFS_CH_C_CTRL: rdata_r <= {24'h0, ch_c_ctrl_r};
            OFS_CH_C_DUTY: rdata_r <= {24'h0, duty_c_low_r};
            OFS_CH_C_HIGH: rdata_r <= {24'h0, ch_c_high_r};
            OFS_IRQ_REG_TWO: rdata_r <= {27'h0, uf_flag_r, 3'b000, uf_ie_r};
            OFS_PRESCALE_READ: rdata_r <= {24'h0, ps_count_r};
            OFS_GLOBAL_IRQ: rdata_r <= {31'h0, gie_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end
   end
   assign hrdata = rdata_r;

   // ************************************************************
   // clock source, edge and prescaler
   // ************************************************************
   logic pin_s1_r, pin_s2_r, pin_s3_r;
   logic src_tick;
   logic ps_tick;
   logic run;
   logic [8:0] ps_limit;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
      end else begin
         pin_s1_r <= ext_count_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   assign run = ctrl_a_r[BIT_RUN];
   always_comb begin
      if (ctrl_b_r[BIT_SRC]) begin
         if (ctrl_b_r[BIT_EDGE]) src_tick = pin_s3_r && !pin_s2_r;
         else src_tick = !pin_s3_r && pin_s2_r;
      end else begin
         src_tick = 1'b1;
      end
   end

   // ratio field n divides by 2^(n+1)
   assign ps_limit = 9'(9'h002 << ctrl_b_r[2:0]);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ps_count_r <= 8'h00;
      end else if (!run || ctrl_b_r[BIT_PS_EN_N]) begin
         ps_count_r <= 8'h00;
      end else if (src_tick) begin
         if ({1'b0, ps_count_r} == 9'(ps_limit - 9'h001)) ps_count_r <= 8'h00;
         else ps_count_r <= ps_count_r + 8'h01;
      end
   end

   assign ps_tick = run && src_tick &&
      (ctrl_b_r[BIT_PS_EN_N] || ({1'b0, ps_count_r} == 9'(ps_limit - 9'h001)));

   // ************************************************************
   // down counter
   // ************************************************************
   logic [9:0] reload_val;
   logic low_wr;
   logic [9:0] duty_a_buf, duty_b_buf, duty_c_buf;

   assign reload_val = {shared_high_r[BIT_RELOAD_HI +: 2], reload_low_r};
   assign low_wr = is_wr(OFS_RELOAD_LOW, wr_addr_r, wr_now);
   assign underflow = ps_tick && (count_r == '0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_r <= RST_COUNT;
      end else if (!run) begin
         if (low_wr) count_r <= {shared_high_r[BIT_RELOAD_HI +: 2], hwdata[7:0]};
      end else if (ps_tick) begin
         if (count_r != '0) count_r <= count_r - 1'b1;
         else if (ctrl_a_r[BIT_ONESHOT]) count_r <= count_r;
         else if (ctrl_a_r[BIT_RELOAD]) count_r <= reload_val;
         else count_r <= FREE_RUN_START;
      end
   end

   // one-shot end is recorded in oneshot_done_r, which blocks further flag sets; the run bit stays set
   logic oneshot_done_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) oneshot_done_r <= 1'b0;
      else if (is_wr(OFS_TIMER_CTRL_A, wr_addr_r, wr_now)) oneshot_done_r <= 1'b0;
      else if (underflow && ctrl_a_r[BIT_ONESHOT]) oneshot_done_r <= 1'b1;
   end

   // ************************************************************
   // underflow flag; set wins over a software clear
   // ************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) uf_flag_r <= 1'b0;
      else if (underflow && !oneshot_done_r) uf_flag_r <= 1'b1;
      else if (is_wr(OFS_IRQ_REG_TWO, wr_addr_r, wr_now) && !hwdata[BIT_UF_FLAG])
         uf_flag_r <= 1'b0;
   end
   assign irq_req = uf_flag_r && uf_ie_r && gie_r;

   // ************************************************************
   // pwm channels: duty latched at underflow, shared frame
   // ************************************************************
   assign duty_a_buf = {shared_high_r[BIT_A_HI +: 2], duty_a_low_r};
   assign duty_b_buf = {shared_high_r[BIT_B_HI +: 2], duty_b_low_r};
   assign duty_c_buf = {ch_c_high_r[1:0], duty_c_low_r};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty_a_r <= 10'h000;
         duty_b_r <= 10'h000;
         duty_c_r <= 10'h000;
      end else if (underflow || !run) begin
         duty_a_r <= duty_a_buf;
         duty_b_r <= duty_b_buf;
         duty_c_r <= duty_c_buf;
      end
   end

   // ticks elapsed in frame: frame starts at reload value, or at 0x3ff in free-run; duty assumed <= frame
   logic [9:0] elapsed_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) elapsed_r <= 10'h000;
      else if (!run || underflow) elapsed_r <= 10'h000;
      else if (ps_tick) elapsed_r <= elapsed_r + 10'h001;
   end

   function automatic logic pwm_out(input logic [9:0] duty, input logic [9:0] el,
                                    input logic low);
      pwm_out = (el < duty) ^ low;
   endfunction : pwm_out

   logic [2:0] level_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         level_r <= 3'b000;
      end else begin
         level_r[0] <= pwm_out(duty_a_r, elapsed_r, ctrl_a_r[BIT_POL]);
         level_r[1] <= pwm_out(duty_b_r, elapsed_r, ch_b_ctrl_r[BIT_POL]);
         level_r[2] <= pwm_out(duty_c_r, elapsed_r, ch_c_ctrl_r[BIT_POL]);
      end
   end
   assign pwm_level = level_r;

   // each channel owns pins 2k and 2k+1; pin_sel picks one
   logic [2:0] oen;
   assign oen = {ch_c_ctrl_r[BIT_OEN], ch_b_ctrl_r[BIT_OEN], ctrl_a_r[BIT_OEN]};
   always_comb begin
      pin_out = 6'h00;
      pin_oe = 6'h00;
      for (int k = 0; k < 3; k++) begin
         pin_out[2*k + int'(pin_sel[k])] = level_r[k];
         pin_oe[2*k + int'(pin_sel[k])] = oen[k];
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_flag_on_uf;
      @(posedge hclk) disable iff (!hresetn)
         (underflow && !oneshot_done_r) |=> uf_flag_r;
   endproperty
   a_flag_on_uf: assert property (p_flag_on_uf) else $error("flag not set");

   // a bus write in the same cycle may change a mask, so it is left out
   property p_irq;
      @(posedge hclk) disable iff (!hresetn)
         (underflow && !oneshot_done_r && uf_ie_r && gie_r && !wr_now) |=> irq_req;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   property p_count_dec;
      @(posedge hclk) disable iff (!hresetn)
         (run && ps_tick && count_r != '0) |=> count_r == $past(count_r) - 1'b1;
   endproperty
   a_count_dec: assert property (p_count_dec) else $error("count not decremented");

   property p_hold_stopped;
      @(posedge hclk) disable iff (!hresetn)
         (!run && !low_wr) |=> $stable(count_r);
   endproperty
   a_hold_stopped: assert property (p_hold_stopped) else $error("count moved stopped");

   property p_load_stopped;
      @(posedge hclk) disable iff (!hresetn)
         (!run && low_wr) |=> count_r[7:0] == $past(hwdata[7:0]);
   endproperty
   a_load_stopped: assert property (p_load_stopped) else $error("no immediate load");

   property p_free_run;
      @(posedge hclk) disable iff (!hresetn)
         (run && underflow && !ctrl_a_r[BIT_ONESHOT] && !ctrl_a_r[BIT_RELOAD])
            |=> count_r == FREE_RUN_START;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free run start wrong");

   property p_oneshot;
      @(posedge hclk) disable iff (!hresetn)
         (run && underflow && ctrl_a_r[BIT_ONESHOT]) |=> count_r == '0;
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one shot restarted");

   property p_duty_hold;
      @(posedge hclk) disable iff (!hresetn)
         (run && !underflow) |=> $stable(duty_a_r);
   endproperty
   a_duty_hold: assert property (p_duty_hold) else $error("duty changed mid frame");

   property p_zero_duty;
      @(posedge hclk) disable iff (!hresetn)
         (duty_a_r == 10'h000 && !ctrl_a_r[BIT_POL]) |=> !level_r[0];
   endproperty
   a_zero_duty: assert property (p_zero_duty) else $error("zero duty active");

   property p_reload_uf;
      @(posedge hclk) disable iff (!hresetn)
         (run && underflow && !ctrl_a_r[BIT_ONESHOT] && ctrl_a_r[BIT_RELOAD])
            |=> count_r == $past(reload_val);
   endproperty
   a_reload_uf: assert property (p_reload_uf) else $error("reload not applied");

   property p_pin_route;
      @(posedge hclk) disable iff (!hresetn)
         ctrl_a_r[BIT_OEN] |-> (pin_oe[pin_sel[0]] && (pin_out[pin_sel[0]] == level_r[0]));
   endproperty
   a_pin_route: assert property (p_pin_route) else $error("channel a pin not driven");

   // an underflow in the same cycle keeps the flag, so it is excluded
   property p_flag_clear;
      @(posedge hclk) disable iff (!hresetn)
         (is_wr(OFS_IRQ_REG_TWO, wr_addr_r, wr_now) && !hwdata[BIT_UF_FLAG] && !underflow)
            |=> !uf_flag_r;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   c_underflow: cover property (@(posedge hclk) disable iff (!hresetn) underflow);
   c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq_req);
   c_pwm_edge: cover property (@(posedge hclk) disable iff (!hresetn) $fell(level_r[0]));
   c_oneshot: cover property (@(posedge hclk) disable iff (!hresetn) $rose(oneshot_done_r));
endmodule : down_timer_triple_pwm
`default_nettype wire

// *** verif/down_timer_triple_pwm_tb_top.sv ***
// self-checking bench for the down timer and its three pwm channels
`timescale 1ns/1ps
`default_nettype none
module down_timer_triple_pwm_tb_top;
   import down_timer_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic ext_count_pin = 1'b0;
   logic [2:0] pin_sel = 3'b010;
   wire logic hready;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq_req;
   logic [2:0] pwm_level;
   logic [5:0] pin_out;
   logic [5:0] pin_oe;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [31:0] ps0;
   logic [9:0] cnt;
   int na;
   int nb;
   int nc;
   // single slave: its ready is the bus ready
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   down_timer_triple_pwm DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_count_pin(ext_count_pin),
      .pin_sel(pin_sel), .irq_req(irq_req), .pwm_level(pwm_level), .pin_out(pin_out),
      .pin_oe(pin_oe));
   // ************************************************************
   // bus and comparison tasks
   // ************************************************************
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 100) begin
         @(posedge hclk);
         n++;
      end
   endtask : wait_rdy
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      wait_rdy();
      d = hrdata;
   endtask : bus_rd
   task automatic rd_count(output logic [9:0] c);
      logic [31:0] lo;
      logic [31:0] hi;
      bus_rd(OFS_RELOAD_LOW, lo);
      bus_rd(OFS_SHARED_HIGH, hi);
      c = {hi[5:4], lo[7:0]};
   endtask : rd_count
   task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %0s expected %0h seen %0h", nm, e, s);
      end
   endtask : cmp_val
   task automatic cmp_in(input string nm, input int lo, input int hi, input logic [9:0] s);
      logic ok;
      ok = (s >= lo) && (s <= hi);
      compares++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("wrong value %0s expected %0h..%0h seen %0h", nm, lo, hi, s);
      end
   endtask : cmp_in
   task automatic cmp_cnt(input string nm, input int e, input int s);
      compares++;
      if (s != e) begin
         bad_count++;
         $display("wrong value %0s expected %0d seen %0d", nm, e, s);
      end
   endtask : cmp_cnt
   task automatic done_test(input string nm);
      $display("test %0s done", nm);
   endtask : done_test
   // frame of 17 ticks, four frames sampled
   task automatic count_hi(output int a, output int b, output int c);
      a = 0;
      b = 0;
      c = 0;
      repeat (68) begin
         @(posedge hclk);
         if (pwm_level[0] === 1'b1) a++;
         if (pwm_level[1] === 1'b1) b++;
         if (pwm_level[2] === 1'b1) c++;
      end
   endtask : count_hi
   // pin is synchronised, so each level is held four clocks
   task automatic toggle_pin(input int n);
      repeat (n) begin
         ext_count_pin <= ~ext_count_pin;
         repeat (4) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
   endtask : toggle_pin
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 6000) begin
         bad_count++;
         $display("wrong value run length expected below 6000 seen %0d", cycles);
         close_out();
      end
   end
   // ************************************************************
   // test sequence
   // ************************************************************
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus_rd(OFS_TIMER_CTRL_A, rd);
      cmp_val("ctrl_a reset", {24'h0, RST_CTRL}, rd);
      bus_rd(OFS_TIMER_CTRL_B, rd);
      cmp_val("ctrl_b reset", {24'h0, RST_CTRL_B}, rd);
      rd_count(cnt);
      cmp_val("count reset", {22'h0, RST_COUNT}, {22'h0, cnt});
      bus_rd(8'h3c, rd);
      cmp_val("unmapped read", 32'h0000_0000, rd);
      cmp_val("hresp", 32'h0, {31'h0, hresp});
      done_test("reset");
      bus_wr(OFS_SHARED_HIGH, 32'h0000_0010);
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0023);
      rd_count(cnt);
      cmp_val("stopped load", 32'h123, {22'h0, cnt});
      done_test("stopped load");
      bus_wr(OFS_SHARED_HIGH, 32'h0000_0000);
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0020);
      bus_wr(OFS_TIMER_CTRL_B, 32'h0000_0028);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0001);
      toggle_pin(10);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0000);
      rd_count(cnt);
      cmp_val("rising edges", 32'h1b, {22'h0, cnt});
      bus_wr(OFS_TIMER_CTRL_B, 32'h0000_0038);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0001);
      toggle_pin(10);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0000);
      rd_count(cnt);
      cmp_val("falling edges", 32'h16, {22'h0, cnt});
      done_test("external source");
      bus_wr(OFS_TIMER_CTRL_B, 32'h0000_0000);
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0040);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0001);
      repeat (40) @(posedge hclk);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0000);
      rd_count(cnt);
      cmp_in("ratio 1:2", 'h29, 'h2d, cnt);
      bus_wr(OFS_TIMER_CTRL_B, 32'h0000_0007);
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0040);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0001);
      bus_rd(OFS_PRESCALE_READ, ps0);
      repeat (50) @(posedge hclk);
      bus_rd(OFS_PRESCALE_READ, rd);
      cmp_val("prescale count moves", 32'h1, {31'h0, rd !== ps0});
      repeat (500) @(posedge hclk);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0000);
      rd_count(cnt);
      cmp_in("ratio 1:256", 'h3d, 'h3e, cnt);
      done_test("prescaler");
      // all duties set while stopped, so the first frame uses them
      bus_wr(OFS_TIMER_CTRL_B, 32'h0000_0008);
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0010);
      bus_wr(OFS_CH_A_DUTY, 32'h0000_0004);
      bus_wr(OFS_CH_B_DUTY, 32'h0000_0008);
      bus_wr(OFS_CH_C_HIGH, 32'h0000_0000);
      bus_wr(OFS_CH_C_DUTY, 32'h0000_0010);
      bus_wr(OFS_CH_B_CTRL, 32'h0000_0083);
      bus_wr(OFS_CH_C_CTRL, 32'h0000_00c3);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0083);
      repeat (40) @(posedge hclk);
      count_hi(na, nb, nc);
      cmp_cnt("ch a active", 16, na);
      cmp_cnt("ch b active", 32, nb);
      cmp_cnt("ch c active low", 4, nc);
      cmp_val("pin enables", 32'h19, {26'h0, pin_oe});
      pin_sel <= 3'b101;
      repeat (2) @(posedge hclk);
      cmp_val("pin enables swapped", 32'h26, {26'h0, pin_oe});
      cmp_val("pin a data", {31'h0, pwm_level[0]}, {31'h0, pin_out[1]});
      done_test("pwm");
      bus_wr(OFS_CH_A_DUTY, 32'h0000_0000);
      repeat (40) @(posedge hclk);
      count_hi(na, nb, nc);
      cmp_cnt("ch a duty zero", 0, na);
      cmp_cnt("ch b unchanged", 32, nb);
      done_test("duty update");
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0080);
      rd_count(cnt);
      cmp_in("reload held", 0, 'h10, cnt);
      repeat (40) @(posedge hclk);
      rd_count(cnt);
      cmp_in("reload applied", 'h50, 'h80, cnt);
      done_test("buffered reload");
      bus_rd(OFS_IRQ_REG_TWO, rd);
      cmp_val("flag set", 32'h10, {24'h0, rd[7:0]});
      cmp_val("irq masked", 32'h0, {31'h0, irq_req});
      bus_wr(OFS_IRQ_REG_TWO, 32'h0000_0011);
      bus_wr(OFS_GLOBAL_IRQ, 32'h0000_0001);
      @(posedge hclk);
      cmp_val("irq raised", 32'h1, {31'h0, irq_req});
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0000);
      bus_wr(OFS_IRQ_REG_TWO, 32'h0000_0001);
      bus_rd(OFS_IRQ_REG_TWO, rd);
      cmp_val("flag cleared", 32'h01, {24'h0, rd[7:0]});
      cmp_val("irq dropped", 32'h0, {31'h0, irq_req});
      done_test("interrupt");
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0005);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0005);
      repeat (30) @(posedge hclk);
      rd_count(cnt);
      cmp_val("one shot end", 32'h0, {22'h0, cnt});
      cmp_val("one shot irq", 32'h1, {31'h0, irq_req});
      bus_wr(OFS_IRQ_REG_TWO, 32'h0000_0001);
      repeat (30) @(posedge hclk);
      rd_count(cnt);
      cmp_val("one shot stays", 32'h0, {22'h0, cnt});
      cmp_val("one shot no refire", 32'h0, {31'h0, irq_req});
      done_test("one shot");
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0000);
      bus_wr(OFS_RELOAD_LOW, 32'h0000_0003);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0001);
      repeat (20) @(posedge hclk);
      bus_wr(OFS_TIMER_CTRL_A, 32'h0000_0000);
      rd_count(cnt);
      cmp_in("free run restart", 'h3e0, 'h3fe, cnt);
      bus_wr(OFS_GLOBAL_IRQ, 32'h0000_0000);
      @(posedge hclk);
      cmp_val("global mask", 32'h0, {31'h0, irq_req});
      done_test("free run");
      close_out();
   end
endmodule : down_timer_triple_pwm_tb_top
`default_nettype wire
